// >>> mrc_consts.svh
// Constants of the run-control register bank: indexes, bit positions, resets
// Included by bare name from the bank's top module, its checker and its bench
`ifndef MRC_CONSTS_SVH
`define MRC_CONSTS_SVH

// Register indexes on the register port
`define MRC_IDX_CTRL 8'h00
`define MRC_IDX_PTR_LO 8'h01
`define MRC_IDX_PTR_HI 8'h02
`define MRC_IDX_MASKS 8'h03
`define MRC_IDX_SHD_LO 8'h10
`define MRC_IDX_SHD_HI 8'h11

// Control/status bit positions
`define MRC_B_LOAD 0
`define MRC_B_RUN 1
`define MRC_B_HALT 2
`define MRC_B_POLL 3
`define MRC_B_TXON 4
`define MRC_B_RXON 5
`define MRC_B_IE 6
`define MRC_B_SUM 7
`define MRC_B_ERR 15

// Mask register bit positions
`define MRC_B_USD 6
`define MRC_B_FLAG0 8
`define MRC_B_BABBLE_FLAG 14

// Number of maskable status flags
`define MRC_NFLAG 6

// Reset values
`define MRC_MASK_RST 6'h00
`define MRC_CTRL_RST 1'b0
`define MRC_HALT_RST 1'b1

`endif

// >>> mrc_pkg.sv
// Types shared by the run-control register bank
// No dependencies
package mrc_pkg;

  typedef enum logic [0:0] {
    MRC_SETUP_IDLE,
    MRC_SETUP_FETCH
  } mrc_setup_state_t;

endpackage

// >>> mrc_flag_cell.sv
// One sticky status flag: hardware sets, software writes one to clear
// Assumes one clock; halt clears the flag
`timescale 1ns/10ps
`default_nettype none
module mrc_flag_cell
  import mrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic set_evt,
  input wire logic clr_w1,
  input wire logic clr_halt,
  output logic flag
);

  logic flag_reg;

  // Halt stops everything; otherwise a new event beats a software clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      flag_reg <= 1'b0;
    else if (clr_halt)
      flag_reg <= 1'b0;
    else if (set_evt)
      flag_reg <= 1'b1;
    else if (clr_w1)
      flag_reg <= 1'b0;
  end

  assign flag = flag_reg;

endmodule // mrc_flag_cell
`default_nettype wire

// >>> mrc_setup_seq.sv
// Setup-block fetch sequencer: one fetch request per start, done pulse at end
// Assumes the memory side raises fetch_ack once the block is read in
`timescale 1ns/10ps
`default_nettype none
module mrc_setup_seq
  import mrc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic abort,
  input wire logic fetch_ack,
  output logic fetch_req,
  output logic busy,
  output logic done
);

  mrc_setup_state_t state_reg;
  logic done_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= MRC_SETUP_IDLE;
    else if (abort)
      state_reg <= MRC_SETUP_IDLE;
    else
    begin
      unique case (state_reg)
        MRC_SETUP_IDLE:
          if (start)
            state_reg <= MRC_SETUP_FETCH;
        MRC_SETUP_FETCH:
          if (fetch_ack)
            state_reg <= MRC_SETUP_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      done_reg <= 1'b0;
    else
      done_reg <= !abort && state_reg == MRC_SETUP_FETCH && fetch_ack;
  end

  assign fetch_req = state_reg == MRC_SETUP_FETCH;
  assign busy = state_reg == MRC_SETUP_FETCH;
  assign done = done_reg;

endmodule // mrc_setup_seq
`default_nettype wire

// >>> mrc_top.sv
// Run-control, setup pointer and interrupt mask registers of the MAC
// Assumes a single software master on the register port, one clock
//
// Behaviour
// [RULE1] Halt set stops all external activity until run or setup-load is set
// [RULE2] Halt written with run and setup-load in one write wins over both
// [RULE3] Halt set by write one or reset; cleared by run or setup-load
// [RULE4] Run enables transmit, receive and buffer management, clears halt; a run written alone while a setup fetch is busy enables nothing
// [RULE5] Run and setup-load together: setup finishes before transmit and receive
// [RULE6] Run set by write one; write zero ignored; halt clears it
// [RULE7] Setup-load starts the setup-block fetch and clears halt
// [RULE8] Setup-load stays set after the fetch completes
// [RULE9] Setup-load set by write one; cleared by reset or halt
// [RULE10] Reset or halt clears the transmit poll demand
// [RULE11] Software writes low pointer with bit zero kept at zero
// [RULE12] Low pointer write also copies into the low shadow register
// [RULE13] Pointers accessible only in halt or suspend; reset leaves them alone
// [RULE14] Software writes upper address bits, zeros in bits 15 to 8
// [RULE15] High pointer write also copies into the high shadow register
// [RULE16] Babble, missed-frame, memory-error masks keep their flags off the summary
// [RULE17] Receive, transmit, setup-done masks keep their flags off the summary
// [RULE18] Reset clears every mask; halt leaves masks unchanged
// [RULE19] Mask bits 15, 13 and 7 written zero, read value free
// [RULE20] Mask bit 6 disables the transmit stop on underflow
// [RULE21] Underflow with stop not disabled turns transmit off; an underflow in the same cycle as go_now leaves transmit on
// [RULE22] Interrupt request only when enable bit and summary flag both set
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mrc_consts.svh"
module mrc_top
  import mrc_pkg::*;
#(
  parameter int NFLAG = `MRC_NFLAG
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic suspend_bit,
  input wire logic babble_evt,
  input wire logic miss_evt,
  input wire logic merr_evt,
  input wire logic rx_done_evt,
  input wire logic tx_done_evt,
  input wire logic transmit_underflow_error,
  input wire logic poll_ack,
  input wire logic fetch_ack,
  output logic fetch_req,
  output logic [23:0] setup_block_pointer,
  output logic tx_enable,
  output logic rx_enable,
  output logic bmu_enable,
  output logic link_active,
  output logic transmit_poll_demand,
  output logic irq
);

  // ***************************************************
  // Write decode
  // ***************************************************
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_masks;
  logic ptr_open;
  logic halt_set;
  logic run_set;
  logic load_set;
  logic halt_reg;
  logic usd_reg;

  assign wr_ctrl = reg_wr && reg_addr == `MRC_IDX_CTRL;
  assign wr_masks = reg_wr && reg_addr == `MRC_IDX_MASKS;
  assign ptr_open = halt_reg || suspend_bit; // RULE13
  assign wr_lo = reg_wr && reg_addr == `MRC_IDX_PTR_LO && ptr_open; // RULE13
  assign wr_hi = reg_wr && reg_addr == `MRC_IDX_PTR_HI && ptr_open; // RULE13

  // Halt in the same write suppresses run and setup-load
  assign halt_set = wr_ctrl && reg_wdata[`MRC_B_HALT]; // RULE2
  assign run_set = wr_ctrl && reg_wdata[`MRC_B_RUN] && !halt_set; // RULE2
  assign load_set = wr_ctrl && reg_wdata[`MRC_B_LOAD] && !halt_set; // RULE2

  // ***************************************************
  // Run control
  // ***************************************************
  logic run_reg;
  logic load_reg;
  logic ie_reg;
  logic txon_reg;
  logic rxon_reg;
  logic poll_reg;
  logic run_wait_reg;
  logic setup_busy;
  logic setup_done;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      halt_reg <= `MRC_HALT_RST; // RULE3
    else if (halt_set)
      halt_reg <= 1'b1; // RULE3
    else if (run_set || load_set)
      halt_reg <= 1'b0; // RULE3 RULE4 RULE7
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      run_reg <= `MRC_CTRL_RST;
    else if (halt_set)
      run_reg <= 1'b0; // RULE6
    else if (run_set)
      run_reg <= 1'b1; // RULE6
  end

  // Setup-load is not cleared when the fetch completes
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      load_reg <= `MRC_CTRL_RST; // RULE9
    else if (halt_set)
      load_reg <= 1'b0; // RULE9
    else if (load_set)
      load_reg <= 1'b1; // RULE8 RULE9
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ie_reg <= `MRC_CTRL_RST;
    else if (halt_set)
      ie_reg <= 1'b0;
    else if (wr_ctrl)
      ie_reg <= reg_wdata[`MRC_B_IE];
  end

  // Run written with setup-load waits for the fetch to finish
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      run_wait_reg <= 1'b0;
    else if (halt_set || setup_done)
      run_wait_reg <= 1'b0;
    else if (run_set && load_set)
      run_wait_reg <= 1'b1; // RULE5
  end

  logic go_now;
  assign go_now = (run_set && !load_set && !setup_busy)
    || (setup_done && run_wait_reg); // RULE4 RULE5

  // Underflow stops the transmitter unless software disabled that or go_now turns it on in the same cycle
  logic transmit_underflow_error_stop;
  assign transmit_underflow_error_stop = transmit_underflow_error && !usd_reg; // RULE20 RULE21

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      txon_reg <= 1'b0;
    else if (halt_set)
      txon_reg <= 1'b0; // RULE1
    else if (go_now)
      txon_reg <= 1'b1; // RULE4
    else if (transmit_underflow_error_stop)
      txon_reg <= 1'b0; // RULE21
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rxon_reg <= 1'b0;
    else if (halt_set)
      rxon_reg <= 1'b0; // RULE1
    else if (go_now)
      rxon_reg <= 1'b1; // RULE4
  end

  // Poll demand only holds while transmit is on; set wins over the ack
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      poll_reg <= 1'b0; // RULE10
    else if (halt_set || !txon_reg)
      poll_reg <= 1'b0; // RULE10
    else if (wr_ctrl && reg_wdata[`MRC_B_POLL])
      poll_reg <= 1'b1;
    else if (poll_ack)
      poll_reg <= 1'b0;
  end

  mrc_setup_seq u_setup
  (
    .clk(clk),
    .nrst(nrst),
    .start(load_set), // RULE7
    .abort(halt_set),
    .fetch_ack(fetch_ack),
    .fetch_req(fetch_req),
    .busy(setup_busy),
    .done(setup_done)
  );

  // ***************************************************
  // Setup pointer and shadows
  // ***************************************************
  // No reset: contents survive a hardware reset
  logic [15:0] ptr_lo_reg;
  logic [7:0] ptr_hi_reg;
  logic [15:0] shd_lo_reg;
  logic [7:0] shd_hi_reg;

  always_ff @(posedge clk)
  begin
    if (wr_lo)
    begin
      ptr_lo_reg <= reg_wdata; // RULE13
      shd_lo_reg <= reg_wdata; // RULE12
    end
  end

  // Upper byte is stored narrow, so bits 15 to 8 read as zero
  always_ff @(posedge clk)
  begin
    if (wr_hi)
    begin
      ptr_hi_reg <= reg_wdata[7:0]; // RULE13
      shd_hi_reg <= reg_wdata[7:0]; // RULE15
    end
  end

  assign setup_block_pointer = {ptr_hi_reg, ptr_lo_reg};

  // ***************************************************
  // Masks and status flags
  // ***************************************************
  logic [NFLAG-1:0] mask_reg;
  logic [NFLAG-1:0] flag_evt;
  logic [NFLAG-1:0] flag;
  logic [NFLAG-1:0] flag_w1c;
  logic [NFLAG-1:0] flag_live;

  // Halt does not touch the masks
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_reg <= `MRC_MASK_RST; // RULE18
      usd_reg <= 1'b0;
    end
    else if (wr_masks)
    begin
      mask_reg <= mask_pos(reg_wdata); // RULE16 RULE17 RULE19
      usd_reg <= reg_wdata[`MRC_B_USD]; // RULE20
    end
  end

  // Flags 0..4 sit at bits 8..12, flag 5 (babble) at bit 14
  function automatic logic [NFLAG-1:0] mask_pos(input logic [15:0] w);
    mask_pos = {w[`MRC_B_BABBLE_FLAG], w[12:`MRC_B_FLAG0]};
  endfunction

  assign flag_evt = {babble_evt, miss_evt, merr_evt, rx_done_evt, tx_done_evt,
    setup_done};
  assign flag_w1c = wr_ctrl ? mask_pos(reg_wdata) : '0;

  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++)
    begin : g_flag
      mrc_flag_cell u_cell
      (
        .clk(clk),
        .nrst(nrst),
        .set_evt(flag_evt[gi]),
        .clr_w1(flag_w1c[gi]),
        .clr_halt(halt_set),
        .flag(flag[gi])
      );
      assign flag_live[gi] = flag[gi] && !mask_reg[gi]; // RULE16 RULE17
    end
  endgenerate

  logic summary_flag;
  assign summary_flag = |flag_live;

  // ***************************************************
  // Read port
  // ***************************************************
  logic [15:0] rdata_reg;
  logic [15:0] ctrl_view;
  logic [15:0] mask_view;

  always_comb
  begin
    ctrl_view = '0;
    ctrl_view[`MRC_B_ERR] = flag[5] || flag[4] || flag[3];
    ctrl_view[`MRC_B_BABBLE_FLAG] = flag[5];
    ctrl_view[12:`MRC_B_FLAG0] = flag[4:0];
    ctrl_view[`MRC_B_SUM] = summary_flag;
    ctrl_view[`MRC_B_IE] = ie_reg;
    ctrl_view[`MRC_B_RXON] = rxon_reg;
    ctrl_view[`MRC_B_TXON] = txon_reg;
    ctrl_view[`MRC_B_POLL] = poll_reg;
    ctrl_view[`MRC_B_HALT] = halt_reg;
    ctrl_view[`MRC_B_RUN] = run_reg;
    ctrl_view[`MRC_B_LOAD] = load_reg;
  end

  // Reserved mask bits read as zero
  always_comb
  begin
    mask_view = '0;
    mask_view[`MRC_B_BABBLE_FLAG] = mask_reg[5];
    mask_view[12:`MRC_B_FLAG0] = mask_reg[4:0];
    mask_view[`MRC_B_USD] = usd_reg; // RULE19
  end

  // Locked pointers and unmapped indexes read as zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= '0;
    else if (!reg_rd)
      rdata_reg <= '0;
    else
    begin
      unique case (reg_addr)
        `MRC_IDX_CTRL:
          rdata_reg <= ctrl_view;
        `MRC_IDX_PTR_LO:
          rdata_reg <= ptr_open ? ptr_lo_reg : '0; // RULE13
        `MRC_IDX_PTR_HI:
          rdata_reg <= ptr_open ? {8'h00, ptr_hi_reg} : '0; // RULE13
        `MRC_IDX_MASKS:
          rdata_reg <= mask_view;
        `MRC_IDX_SHD_LO:
          rdata_reg <= shd_lo_reg;
        `MRC_IDX_SHD_HI:
          rdata_reg <= {8'h00, shd_hi_reg};
        default:
          rdata_reg <= '0;
      endcase
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign reg_rdata = rdata_reg;
  assign tx_enable = txon_reg;
  assign rx_enable = rxon_reg;
  assign bmu_enable = txon_reg || rxon_reg; // RULE4
  assign link_active = !halt_reg; // RULE1
  assign transmit_poll_demand = poll_reg;
  // Interrupt pin stays quiet while halted, even if enable was rewritten
  assign irq = ie_reg && summary_flag && !halt_reg; // RULE1 RULE22

endmodule // mrc_top
`default_nettype wire

// >>> mrc_top_checker.sv
// Port-level checks of the run-control register bank
// Assumes one clock and is bound to the bank's top module
`timescale 1ns/10ps
`default_nettype none
`include "mrc_consts.svh"
module mrc_top_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic suspend_bit,
  input wire logic transmit_underflow_error,
  input wire logic fetch_ack,
  input wire logic fetch_req,
  input wire logic [23:0] setup_block_pointer,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic link_active,
  input wire logic transmit_poll_demand,
  input wire logic irq
);
  // Mirror of the stop-disable bit, so underflow checks know the mode
  logic usd_q;
  wire logic ctl_w = reg_wr && reg_addr == `MRC_IDX_CTRL;
  wire logic ptr_w = reg_wr && (reg_addr == `MRC_IDX_PTR_LO || reg_addr == `MRC_IDX_PTR_HI);

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      usd_q <= 1'b0;
    else if (reg_wr && reg_addr == `MRC_IDX_MASKS)
      usd_q <= reg_wdata[`MRC_B_USD];

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ******
  // Checks
  // ******
  chk_halt_wins: assert property (ctl_w && reg_wdata[2] |=> !link_active && !fetch_req)
    else $error("halt write left the bank active");
  chk_halted_quiet: assert property (!link_active |->
    !tx_enable && !rx_enable && !irq && !transmit_poll_demand)
    else $error("activity while halted");
  chk_run_starts: assert property (ctl_w && reg_wdata[1] && !reg_wdata[2] |=> link_active)
    else $error("run write did not leave halt");
  chk_load_fetch: assert property (ctl_w && reg_wdata[0] && !reg_wdata[2] && !link_active
    |=> fetch_req)
    else $error("setup load did not start the fetch");
  chk_fetch_holds: assert property (fetch_req && !fetch_ack && !(ctl_w && reg_wdata[2])
    |=> fetch_req)
    else $error("fetch request dropped early");
  chk_setup_first: assert property (fetch_req |-> !tx_enable ##1 !tx_enable)
    else $error("transmit enabled before setup finished");
  chk_ptr_locked: assert property (ptr_w && link_active && !suspend_bit
    |=> $stable(setup_block_pointer))
    else $error("locked pointer was written");
  chk_uflow_stop: assert property (transmit_underflow_error && !usd_q && !ctl_w
    |=> !tx_enable)
    else $error("underflow left transmit on");
endmodule // mrc_top_checker

bind mrc_top mrc_top_checker i_mrc_top_checker (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .suspend_bit, .transmit_underflow_error, .fetch_ack, .fetch_req, .setup_block_pointer,
  .tx_enable, .rx_enable, .link_active, .transmit_poll_demand, .irq);
`default_nettype wire

// >>> mrc_top_bench.sv
// Self-checking bench of the run-control register bank
// Assumes the checker file is compiled beside it
`timescale 1ns/10ps
`default_nettype none
`include "mrc_consts.svh"
module mrc_top_bench;
  typedef struct packed {
    logic [7:0] wa;
    logic [15:0] wd;
    logic [7:0] ra;
    logic [15:0] exp;
  } mrc_row_t;

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic suspend_bit = 1'b0;
  logic poll_ack = 1'b0;
  // Events, underflow, fetch ack in one vector
  logic [6:0] ev = 7'h00;
  logic [15:0] reg_rdata;
  logic [23:0] setup_block_pointer;
  logic fetch_req, tx_enable, rx_enable, bmu_enable, link_active, transmit_poll_demand, irq;
  int n_errors = 0;
  int samples_checked = 0;
  int bp[5] = '{14, 12, 11, 10, 9};
  mrc_row_t rows[6] = '{
    '{`MRC_IDX_PTR_LO, 16'h1234, `MRC_IDX_PTR_LO, 16'h1234},
    '{`MRC_IDX_PTR_LO, 16'habce, `MRC_IDX_SHD_LO, 16'habce},
    '{`MRC_IDX_PTR_HI, 16'h0056, `MRC_IDX_PTR_HI, 16'h0056},
    '{`MRC_IDX_PTR_HI, 16'h0078, `MRC_IDX_SHD_HI, 16'h0078},
    '{`MRC_IDX_MASKS, 16'h5f40, `MRC_IDX_MASKS, 16'h5f40},
    '{`MRC_IDX_MASKS, 16'h0000, `MRC_IDX_MASKS, 16'h0000}};

  always #10 clk = ~clk;

  mrc_top i_mrc_top (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .suspend_bit, .babble_evt(ev[6]), .miss_evt(ev[5]), .merr_evt(ev[4]), .rx_done_evt(ev[3]),
    .tx_done_evt(ev[2]), .transmit_underflow_error(ev[1]), .poll_ack, .fetch_ack(ev[0]),
    .fetch_req, .setup_block_pointer, .tx_enable, .rx_enable, .bmu_enable, .link_active,
    .transmit_poll_demand, .irq);

  // ******
  // Tasks
  // ******
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("read data", reg_rdata, e);
  endtask

  task automatic pulse(input logic [6:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 7'h00;
    #1;
  endtask

  task automatic close_out;
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Whole run is under two hundred cycles
  initial
  begin
    #40us;
    n_errors++;
    close_out;
  end

  // ******
  // Tests
  // ******
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rc(`MRC_IDX_CTRL, 16'h0004);
    rc(`MRC_IDX_MASKS, 16'h0000);
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rc(rows[i].ra, rows[i].exp);
    end
    check("pointer", setup_block_pointer, 24'h78abce);
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk) nrst <= 1'b1;
    rc(`MRC_IDX_PTR_LO, 16'habce);
    wr(`MRC_IDX_CTRL, 16'h0007);
    check("fetch_req", fetch_req, 1'b0);
    rc(`MRC_IDX_CTRL, 16'h0004);
    wr(`MRC_IDX_MASKS, 16'h0040);
    wr(`MRC_IDX_CTRL, 16'h0002);
    check("enables", {tx_enable, rx_enable, bmu_enable, link_active}, 4'hf);
    wr(`MRC_IDX_CTRL, 16'h0000);
    rc(`MRC_IDX_CTRL, 16'h0032);
    wr(`MRC_IDX_PTR_LO, 16'h1110);
    rc(`MRC_IDX_PTR_LO, 16'h0000);
    check("pointer", setup_block_pointer, 24'h78abce);
    @(posedge clk) suspend_bit <= 1'b1;
    wr(`MRC_IDX_PTR_HI, 16'h0099);
    rc(`MRC_IDX_PTR_HI, 16'h0099);
    @(posedge clk) suspend_bit <= 1'b0;
    wr(`MRC_IDX_CTRL, 16'h0048);
    check("poll", transmit_poll_demand, 1'b1);
    @(posedge clk) poll_ack <= 1'b1;
    @(posedge clk) poll_ack <= 1'b0;
    #1;
    check("poll", transmit_poll_demand, 1'b0);
    pulse(7'h02);
    check("tx_enable", tx_enable, 1'b1);
    wr(`MRC_IDX_MASKS, 16'h0000);
    pulse(7'h02);
    check("tx_enable", tx_enable, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      wr(`MRC_IDX_MASKS, 16'h0001 << bp[i]);
      pulse(7'h40 >> i);
      check("irq", irq, 1'b0);
      wr(`MRC_IDX_MASKS, 16'h0000);
      check("irq", irq, 1'b1);
      wr(`MRC_IDX_CTRL, 16'h0000);
      check("irq", irq, 1'b0);
      wr(`MRC_IDX_CTRL, (16'h0001 << bp[i]) | 16'h0040);
      check("irq", irq, 1'b0);
    end
    wr(`MRC_IDX_CTRL, 16'h0004);
    wr(`MRC_IDX_CTRL, 16'h0003);
    check("fetch_req", fetch_req, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    check("tx_enable", tx_enable, 1'b0);
    pulse(7'h01);
    repeat (10) if (tx_enable !== 1'b1) @(negedge clk);
    check("tx_enable", tx_enable, 1'b1);
    rc(`MRC_IDX_CTRL, 16'h01b3);
    wr(`MRC_IDX_MASKS, 16'h0100);
    rc(`MRC_IDX_CTRL, 16'h0133);
    wr(`MRC_IDX_CTRL, 16'h0008);
    check("poll", transmit_poll_demand, 1'b1);
    wr(`MRC_IDX_CTRL, 16'h0004);
    check("poll", transmit_poll_demand, 1'b0);
    rc(`MRC_IDX_CTRL, 16'h0004);
    rc(`MRC_IDX_MASKS, 16'h0100);
    close_out;
  end
endmodule // mrc_top_bench
`default_nettype wire
